// ### inc/abn_encoder_pkg.sv
// Behaviour
// - add or subtract the factor on every A or B polarity change.
// - binary mode factor is signed 16.16 fixed point.
// - decimal mode low half is 0..9999 ten-thousandths; software keeps it there.
// - a negated factor reverses the counting direction.
// - negatives are two's complement, or decimal integer/10000-fraction complements.
// - position is readable; A, B and N polarity is selectable.
// - continuous index mode acts on every index event.
// - single-shot index mode acts once, then disarms itself.
// - index accepted only while A and B sit at selected levels, unless the ignore-A/B mode bit is set.
// - clear on index needs clear bit plus single-shot or continuous mode.
// - accepted index copies position into the latch register.
// - index clear or latch sets the status event flag.
// - interrupt output is active while the event flag is set.
// - reading status clears the flag; a coinciding event is lost.
// - A, B, N need three stable clocks to pass the filter.
// - filtering limits guaranteed counting rate to two thirds of clock.
// - global configuration enables the encoder; index channel is optional.
package abn_encoder_pkg;
  localparam int          ADDR_W            = 8;
  localparam int          FILTER_CYCLES     = 3;
  localparam logic [7:0]  GLOBAL_CONFIG_OFS = 8'h00;
  localparam logic [7:0]  MODE_CONFIG_OFS   = 8'h04;
  localparam logic [7:0]  POSITION_OFS      = 8'h08;
  localparam logic [7:0]  FACTOR_OFS        = 8'h0C;
  localparam logic [7:0]  STATUS_OFS        = 8'h10;
  localparam logic [7:0]  LATCH_OFS         = 8'h14;
  localparam int          GC_ENC_EN         = 0;
  localparam int          GC_INDEX_EN       = 1;
  localparam int          MD_QUAL_A         = 0;
  localparam int          MD_QUAL_B         = 1;
  localparam int          MD_N_HIGH         = 2;
  localparam int          MD_IGNORE_AB      = 3;
  localparam int          MD_CLR_CONT       = 4;
  localparam int          MD_CLR_ONCE       = 5;
  localparam int          MD_INVERT_AB      = 6;
  localparam int          MD_CLR_POS        = 8;
  localparam int          MD_DECIMAL        = 10;
  localparam int          ST_EVENT          = 0;
  localparam logic [31:0] GLOBAL_CONFIG_RST = 32'h0000_0003;
  localparam logic [31:0] MODE_CONFIG_RST   = 32'h0000_0004;
  localparam logic [31:0] FACTOR_RST        = 32'h0001_0000;
  localparam logic [31:0] GLOBAL_CONFIG_MSK = 32'h0000_0003;
  localparam logic [31:0] MODE_CONFIG_MSK   = 32'h0000_057F;
  localparam logic [16:0] DEC_ONE           = 17'h0_2710;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;
  localparam logic [1:0]  STEP_NONE         = 2'h0;
  localparam logic [1:0]  STEP_UP           = 2'h1;
  localparam logic [1:0]  STEP_DOWN         = 2'h2;
endpackage

// ### verilog/abn_quadrature_encoder_counter.sv
`timescale 1ns/10ps
`default_nettype none
module abn_quadrature_encoder_counter #(
  parameter int FILT = abn_encoder_pkg::FILTER_CYCLES
)(
  input  wire logic                               mclk,
  input  wire logic                               rst_n,
  input  wire logic                               enc_a,
  input  wire logic                               enc_b,
  input  wire logic                               enc_n,
  output var  logic                               irq,
  input  wire logic [abn_encoder_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                               s_axi_awvalid,
  output var  logic                               s_axi_awready,
  input  wire logic [31:0]                        s_axi_wdata,
  input  wire logic [3:0]                         s_axi_wstrb,
  input  wire logic                               s_axi_wvalid,
  output var  logic                               s_axi_wready,
  output var  logic [1:0]                         s_axi_bresp,
  output var  logic                               s_axi_bvalid,
  input  wire logic                               s_axi_bready,
  input  wire logic [abn_encoder_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                               s_axi_arvalid,
  output var  logic                               s_axi_arready,
  output var  logic [31:0]                        s_axi_rdata,
  output var  logic [1:0]                         s_axi_rresp,
  output var  logic                               s_axi_rvalid,
  input  wire logic                               s_axi_rready
);
  import abn_encoder_pkg::*;

  logic [2:0]        sync1;
  logic [2:0]        sync2;
  logic [FILT-1:0]   hist_a;
  logic [FILT-1:0]   hist_b;
  logic [FILT-1:0]   hist_n;
  logic              a_filt;
  logic              b_filt;
  logic              n_filt;
  logic [1:0]        ab_q;
  logic              n_act_q;
  logic [31:0]       global_configuration;
  logic [31:0]       encoder_mode_config;
  logic [31:0]       factor;
  logic [31:0]       acc_int;
  logic [15:0]       acc_frac;
  logic [31:0]       latch;
  logic              event_flag;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              aw_held;
  logic              w_held;
  logic              wr_fire;
  logic              rd_take;
  logic              rd_status;
  logic [1:0]        ab_now;
  logic [1:0]        step;
  logic              n_act;
  logic              qualified;
  logic              index_act;
  logic              index_clear;
  logic              pos_wr;
  logic [47:0]       next_acc;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      r[8*i +: 8] = strb[i] ? data[8*i +: 8] : old[8*i +: 8];
    end
    return r;
  endfunction
  // A leading B counts up: 00 -> 10 -> 11 -> 01 -> 00
  function automatic logic [1:0] quad_step(input logic [1:0] prev, input logic [1:0] now);
    case ({prev, now})
      4'h2, 4'hB, 4'hD, 4'h4: return STEP_UP;
      4'h8, 4'hE, 4'h7, 4'h1: return STEP_DOWN;
      default: return STEP_NONE;
    endcase
  endfunction

  function automatic logic [47:0] dec_step(input logic [31:0] ai, input logic [15:0] af,
                                           input logic [31:0] k, input logic up);
    logic [16:0] fs;
    logic [31:0] ki;
    logic        c;
    ki = {{16{k[31]}}, k[31:16]};
    if (up)
    begin
      fs = {1'b0, af} + {1'b0, k[15:0]};
      c  = (fs >= DEC_ONE);
      fs = c ? fs - DEC_ONE : fs;
      return {ai + ki + {31'h0, c}, fs[15:0]};
    end
    c  = (af < k[15:0]);
    fs = {1'b0, af} - {1'b0, k[15:0]};
    fs = c ? fs + DEC_ONE : fs;
    return {ai - ki - {31'h0, c}, fs[15:0]};
  endfunction
  // pin synchroniser, two stages
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end
    else
    begin
      sync1 <= {enc_n, enc_b, enc_a};
      sync2 <= sync1;
    end
  end

  // spike filter: output follows only a level held for FILT clocks
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hist_a <= '0;
      hist_b <= '0;
      hist_n <= '0;
      a_filt <= 1'b0;
      b_filt <= 1'b0;
      n_filt <= 1'b0;
    end
    else
    begin
      hist_a <= {hist_a[FILT-2:0], sync2[0]};
      hist_b <= {hist_b[FILT-2:0], sync2[1]};
      hist_n <= {hist_n[FILT-2:0], sync2[2]};
      if (&hist_a || ~|hist_a) a_filt <= hist_a[0];
      if (&hist_b || ~|hist_b) b_filt <= hist_b[0];
      if (&hist_n || ~|hist_n) n_filt <= hist_n[0];
    end
  end

  always_comb
  begin
    ab_now      = {a_filt, b_filt} ^ {2{encoder_mode_config[MD_INVERT_AB]}};
    step        = global_configuration[GC_ENC_EN] ? quad_step(ab_q, ab_now) : STEP_NONE;
    n_act       = encoder_mode_config[MD_N_HIGH] ? n_filt : ~n_filt;
    qualified   = encoder_mode_config[MD_IGNORE_AB] ||
                  (ab_now == {encoder_mode_config[MD_QUAL_A], encoder_mode_config[MD_QUAL_B]});
    index_act   = n_act && !n_act_q && qualified && global_configuration[GC_INDEX_EN] &&
                  global_configuration[GC_ENC_EN] &&
                  (encoder_mode_config[MD_CLR_CONT] || encoder_mode_config[MD_CLR_ONCE]);
    index_clear = index_act && encoder_mode_config[MD_CLR_POS];
    wr_fire     = aw_held && w_held && !s_axi_bvalid;
    rd_take     = s_axi_arvalid && s_axi_arready;
    rd_status   = rd_take && (s_axi_araddr == STATUS_OFS);
    pos_wr      = wr_fire && (wr_addr == POSITION_OFS);
    if (encoder_mode_config[MD_DECIMAL])
    begin
      next_acc = dec_step(acc_int, acc_frac, factor, step == STEP_UP);
    end
    else if (step == STEP_UP)
    begin
      next_acc = {acc_int, acc_frac} + {{16{factor[31]}}, factor};
    end
    else
    begin
      next_acc = {acc_int, acc_frac} - {{16{factor[31]}}, factor};
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ab_q    <= 2'h0;
      n_act_q <= 1'b0;
    end
    else
    begin
      ab_q    <= ab_now;
      n_act_q <= n_act;
    end
  end

  // position accumulator; index clear beats a step in the same clock
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_int  <= 32'h0000_0000;
      acc_frac <= 16'h0000;
    end
    else if (index_clear)
    begin
      acc_int  <= 32'h0000_0000;
      acc_frac <= 16'h0000;
    end
    else if (pos_wr)
    begin
      acc_int  <= merge(acc_int, wr_data, wr_strb);
      acc_frac <= 16'h0000;
    end
    else if (step != STEP_NONE)
    begin
      {acc_int, acc_frac} <= next_acc;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latch <= 32'h0000_0000;
    end
    else if (index_act)
    begin
      latch <= acc_int;
    end
  end

  // read of status clears the flag even if an event lands in the same clock
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      event_flag <= 1'b0;
      irq        <= 1'b0;
    end
    else
    begin
      event_flag <= rd_status ? 1'b0 : (event_flag || index_act);
      irq        <= rd_status ? 1'b0 : (event_flag || index_act);
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      global_configuration <= GLOBAL_CONFIG_RST;
      encoder_mode_config  <= MODE_CONFIG_RST;
      factor               <= FACTOR_RST;
    end
    else
    begin
      if (wr_fire && wr_addr == GLOBAL_CONFIG_OFS)
      begin
        global_configuration <= merge(global_configuration, wr_data, wr_strb) & GLOBAL_CONFIG_MSK;
      end
      if (wr_fire && wr_addr == MODE_CONFIG_OFS)
      begin
        encoder_mode_config <= merge(encoder_mode_config, wr_data, wr_strb) & MODE_CONFIG_MSK;
      end
      else if (index_act)
      begin
        encoder_mode_config[MD_CLR_ONCE] <= 1'b0;
      end
      if (wr_fire && wr_addr == FACTOR_OFS)
      begin
        factor <= merge(factor, wr_data, wr_strb);
      end
    end
  end

  // write channels taken in either order, answered after both
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_addr       <= '0;
      wr_data       <= 32'h0000_0000;
      wr_strb       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held       <= 1'b1;
        wr_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held       <= 1'b1;
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_addr <= LATCH_OFS && wr_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      case (s_axi_araddr)
        GLOBAL_CONFIG_OFS: s_axi_rdata <= global_configuration;
        MODE_CONFIG_OFS:   s_axi_rdata <= encoder_mode_config;
        POSITION_OFS:      s_axi_rdata <= acc_int;
        FACTOR_OFS:        s_axi_rdata <= factor;
        STATUS_OFS:        s_axi_rdata <= {31'h0, event_flag};
        LATCH_OFS:         s_axi_rdata <= latch;
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  filter_hold_a: assert property ($changed(a_filt) |-> $past(hist_a) == {FILT{a_filt}})
    else $error("a filter passed an unstable level");
  count_up_a: assert property (step == STEP_UP && !index_clear && !pos_wr && !encoder_mode_config[MD_DECIMAL]
    |=> {acc_int, acc_frac} == $past({acc_int, acc_frac}) + $past({{16{factor[31]}}, factor}))
    else $error("up step did not add the factor");
  dec_range_a: assert property (encoder_mode_config[MD_DECIMAL] && factor[15:0] < DEC_ONE[15:0]
    && acc_frac < DEC_ONE[15:0] |=> acc_frac < DEC_ONE[15:0])
    else $error("decimal fraction left range");
  index_clear_a: assert property (index_clear |=> acc_int == 32'h0000_0000 && acc_frac == 16'h0000)
    else $error("index did not clear position");
  latch_copy_a: assert property (index_act |=> latch == $past(acc_int))
    else $error("latch missed the position");
  latch_hold_a: assert property (!index_act |=> $stable(latch))
    else $error("latch changed without index");
  once_disarm_a: assert property (index_act && !(wr_fire && wr_addr == MODE_CONFIG_OFS)
    |=> !encoder_mode_config[MD_CLR_ONCE])
    else $error("single shot mode stayed armed");
  event_irq_a: assert property (index_act && !rd_status |=> event_flag && irq)
    else $error("index event not flagged");
  status_clear_a: assert property (rd_status |=> !event_flag && !irq)
    else $error("status read did not clear flag");
endmodule
`default_nettype wire

// ### tb/abn_encoder_model.sv
`timescale 1ns/10ps
`default_nettype none
module abn_encoder_model (
  input  wire logic mclk,
  output var  logic enc_a,
  output var  logic enc_b,
  output var  logic enc_n
);
  logic [1:0] ph = 2'h0;
  initial
  begin
    enc_a = 1'h0;
    enc_b = 1'h0;
    enc_n = 1'h0;
  end
  // step holds each level 8 clocks: above the 3-clock filter, below 2/3 rate
  task automatic hold(input int c);
    repeat (c) @(posedge mclk);
  endtask
  // gray order 00,10,11,01 (a,b) counts up
  task automatic step(input bit up);
    ph = up ? ph + 2'h1 : ph - 2'h1;
    enc_a <= ph[0] ^ ph[1];
    enc_b <= ph[1];
    hold(8);
  endtask
  task automatic pulse_n(input int w);
    enc_n <= 1'h1;
    hold(w);
    enc_n <= 1'h0;
    hold(8);
  endtask
  task automatic glitch_a(input int w);
    enc_a <= ~enc_a;
    hold(w);
    enc_a <= ~enc_a;
    hold(8);
  endtask
endmodule
`default_nettype wire

// ### tb/abn_quadrature_encoder_counter_tb.sv
`timescale 1ns/10ps
`default_nettype none
module abn_quadrature_encoder_counter_tb;
  import abn_encoder_pkg::*;
  logic        mclk, rst_n, irq, enc_a, enc_b, enc_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          mismatches = 0, samples_checked = 0, seed = 62610, i, n, num;
  logic [31:0] f, p;
  abn_quadrature_encoder_counter abn_quadrature_encoder_counter_i (.mclk, .rst_n, .enc_a, .enc_b, .enc_n, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  abn_encoder_model abn_encoder_model_i (.mclk, .enc_a, .enc_b, .enc_n);
  initial
  begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic finish_test;
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] st = 4'hF,
                    input logic [1:0] er = RESP_OKAY);
    int t;
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (t = 0; t < 100; t++)
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    chk($sformatf("bresp %h", ad), {30'h0, er}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'h0;
    if (t == 100)
    begin
      mismatches++;
      finish_test;
    end
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
    int t;
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (t = 0; t < 100; t++)
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    chk($sformatf("rdata %h", ad), e, s_axi_rdata);
    chk($sformatf("rresp %h", ad), {30'h0, er}, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'h0;
    if (t == 100)
    begin
      mismatches++;
      finish_test;
    end
    @(posedge mclk);
  endtask
  // integer part of n steps of num/den, rounded toward minus infinity
  function automatic logic [31:0] expo(input int n, input int num, input int den);
    longint a;
    longint q;
    a = longint'(n) * num;
    q = a / den;
    if (a % den != 0 && a < 0) q--;
    return q[31:0];
  endfunction
  // byte lanes with a set strobe take the new data
  function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] st);
    logic [31:0] r;
    for (int b = 0; b < 4; b++) r[8*b +: 8] = st[b] ? d[8*b +: 8] : o[8*b +: 8];
    return r;
  endfunction
  initial
  begin
    rst_n <= 1'h0;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata <= 32'h0000_0000;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    s_axi_bready <= 1'h0;
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    rd(GLOBAL_CONFIG_OFS, GLOBAL_CONFIG_RST, RESP_OKAY);
    rd(MODE_CONFIG_OFS, MODE_CONFIG_RST, RESP_OKAY);
    rd(FACTOR_OFS, FACTOR_RST, RESP_OKAY);
    rd(LATCH_OFS, 32'h0000_0000, RESP_OKAY);
    rd(STATUS_OFS, 32'h0000_0000, RESP_OKAY);
    rd(8'h18, 32'h0000_0000, RESP_SLVERR);
    // factors: one, +k, -k, binary half, decimal 0.3000, decimal -0.5000
    for (i = 0; i < 6; i++)
    begin
      n = ($random(seed) & 7) + 1;
      f = {16'(n), 16'h0000};
      case (i)
        0: f = FACTOR_RST;
        2: f = -f;
        3: f = 32'h0000_8000;
        4: f = 32'h0000_0BB8;
        5: f = 32'hFFFF_1388;
        default: ;
      endcase
      num = (i > 3) ? int'($signed(f[31:16])) * 10000 + int'(f[15:0]) : int'($signed(f));
      wr(MODE_CONFIG_OFS, (i > 3) ? 32'h0000_0404 : MODE_CONFIG_RST);
      wr(FACTOR_OFS, f);
      wr(POSITION_OFS, 32'h0000_0000);
      n = 0;
      repeat (($random(seed) & 3) + 5)
      begin
        p = $random(seed);
        abn_encoder_model_i.step(p[0]);
        n += p[0] ? 1 : -1;
      end
      rd(POSITION_OFS, expo(n, num, (i > 3) ? 10000 : 65536), RESP_OKAY);
    end
    wr(MODE_CONFIG_OFS, MODE_CONFIG_RST);
    wr(FACTOR_OFS, FACTOR_RST);
    wr(POSITION_OFS, 32'h0000_0000);
    abn_encoder_model_i.glitch_a(2);
    abn_encoder_model_i.step(1'h1);
    rd(POSITION_OFS, 32'h0000_0001, RESP_OKAY);
    wr(GLOBAL_CONFIG_OFS, 32'h0000_0000);
    abn_encoder_model_i.step(1'h1);
    rd(POSITION_OFS, 32'h0000_0001, RESP_OKAY);
    wr(GLOBAL_CONFIG_OFS, GLOBAL_CONFIG_RST);
    p = $random(seed) & 32'h0000_7FFF;
    wr(POSITION_OFS, p);
    wr(MODE_CONFIG_OFS, 32'h0000_002C);
    abn_encoder_model_i.pulse_n(6);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    rd(LATCH_OFS, p, RESP_OKAY);
    rd(STATUS_OFS, 32'h0000_0001, RESP_OKAY);
    rd(STATUS_OFS, 32'h0000_0000, RESP_OKAY);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    rd(MODE_CONFIG_OFS, 32'h0000_000C, RESP_OKAY);
    wr(POSITION_OFS, 32'h0000_0123);
    abn_encoder_model_i.pulse_n(6);
    rd(LATCH_OFS, p, RESP_OKAY);
    wr(MODE_CONFIG_OFS, 32'h0000_010C);
    abn_encoder_model_i.pulse_n(6);
    rd(POSITION_OFS, 32'h0000_0123, RESP_OKAY);
    rd(STATUS_OFS, 32'h0000_0000, RESP_OKAY);
    wr(MODE_CONFIG_OFS, 32'h0000_011C);
    for (i = 0; i < 2; i++)
    begin
      p = $random(seed) & 32'h0000_7FFF;
      wr(POSITION_OFS, p);
      abn_encoder_model_i.pulse_n(6);
      rd(LATCH_OFS, p, RESP_OKAY);
      rd(POSITION_OFS, 32'h0000_0000, RESP_OKAY);
    end
    wr(MODE_CONFIG_OFS, 32'h0000_0017);
    rd(STATUS_OFS, 32'h0000_0001, RESP_OKAY);
    while (abn_encoder_model_i.ph != 2'h0) abn_encoder_model_i.step(1'h1);
    abn_encoder_model_i.pulse_n(6);
    rd(STATUS_OFS, 32'h0000_0000, RESP_OKAY);
    abn_encoder_model_i.step(1'h1);
    abn_encoder_model_i.step(1'h1);
    wr(POSITION_OFS, 32'h0000_0456);
    abn_encoder_model_i.pulse_n(6);
    rd(LATCH_OFS, 32'h0000_0456, RESP_OKAY);
    // inverted A/B, N active low, no index action armed
    wr(MODE_CONFIG_OFS, 32'h0000_0040);
    p = $random(seed) & 32'h0000_7FFF;
    wr(POSITION_OFS, p);
    abn_encoder_model_i.step(1'h0);
    abn_encoder_model_i.step(1'h0);
    rd(POSITION_OFS, p - 32'h0000_0002, RESP_OKAY);
    // pins now 00: inverted levels meet the A and B high qualification
    wr(MODE_CONFIG_OFS, 32'h0000_0057);
    abn_encoder_model_i.pulse_n(6);
    rd(LATCH_OFS, p - 32'h0000_0002, RESP_OKAY);
    wr(MODE_CONFIG_OFS, 32'h0000_0048);
    wr(POSITION_OFS, ~p);
    wr(MODE_CONFIG_OFS, 32'h0000_0058);
    abn_encoder_model_i.pulse_n(6);
    rd(LATCH_OFS, ~p, RESP_OKAY);
    wr(LATCH_OFS, p);
    wr(STATUS_OFS, 32'h0000_0000);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    rd(LATCH_OFS, ~p, RESP_OKAY);
    rd(STATUS_OFS, 32'h0000_0001, RESP_OKAY);
    wr(8'h18, p, 4'hF, RESP_SLVERR);
    wr(8'h06, p, 4'hF, RESP_SLVERR);
    rd(8'h06, 32'h0000_0000, RESP_SLVERR);
    rd(MODE_CONFIG_OFS, 32'h0000_0058, RESP_OKAY);
    f = $random(seed);
    n = $random(seed) & 15;
    wr(FACTOR_OFS, f, 4'(n));
    rd(FACTOR_OFS, bmerge(FACTOR_RST, f, 4'(n)), RESP_OKAY);
    finish_test;
  end
endmodule
`default_nettype wire
